// ==== rtl/tp_ctrl.sv ====
// Paper-tape presence watcher, read request gate and punch sequencer.
// Assumes an AHB-Lite master on hclk and asynchronous mechanism pins.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`include "tp_regs.svh"
module tp_ctrl #(
    parameter logic [`TP_CNT_W-1:0] PRES_START_CYC = `TP_CNT_W'(`TP_PRES_START_CYC),
    parameter logic [`TP_CNT_W-1:0] PRES_RUN_CYC   = `TP_CNT_W'(`TP_PRES_RUN_CYC),
    parameter logic [`TP_CNT_W-1:0] RUNOUT_CYC     = `TP_CNT_W'(`TP_RUNOUT_CYC),
    parameter logic [`TP_CNT_W-1:0] FIRE_CYC       = `TP_CNT_W'(`TP_FIRE_CYC),
    parameter logic [`TP_CNT_W-1:0] PCYCLE_CYC     = `TP_CNT_W'(`TP_PCYCLE_CYC)
) (
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    // Mechanism pins
    input  wire tp_pkg::tp_pins_t    pins,
    output tp_pkg::tp_rdr_out_t      rdr,
    output tp_pkg::tp_pun_out_t      pun
);
    import tp_pkg::*;

    localparam logic [7:0] STEP_CYC = 8'(`TP_STEP_CYC);

    tp_state_t q;                // Registered state
    tp_state_t d;                // Next state
    logic      sprk_fall;        // Sprocket trailing edge
    logic      clk_ev;           // Read clock pulse seen
    logic      cap_ev;           // Capture strobe seen
    logic      sync_ev;          // Punch cycle sync seen
    logic      feed_ev;          // Feed switch pressed
    logic      wr_iot;           // Instruction write in data phase
    tp_iot_t   iot;              // Decoded instruction kind
    logic      addr_ok;          // Accepted address phase
    logic      present;          // Presence timer triggered
    tp_pins_t  filt;             // Filtered pin levels

    // Instruction code to its effect
    function automatic tp_iot_t iot_decode(input logic [11:0] code);
        if (code == `TP_IOT_RD0 || code == `TP_IOT_RD1) begin
            return TP_IOT_READ;
        end else if (code == `TP_IOT_PN0 || code == `TP_IOT_PN1) begin
            return TP_IOT_PUNCH;
        end else begin
            return TP_IOT_NONE;
        end
    endfunction : iot_decode

    // Filter: a pin counts once stages two and three agree
    function automatic tp_pins_t pin_filter(input tp_pins_t a, input tp_pins_t b,
                                            input tp_pins_t cur);
        logic [12:0] dis;
        dis = 13'(a ^ b);
        return tp_pins_t'((13'(b) & ~dis) | (13'(cur) & dis));
    endfunction : pin_filter

    // Edges on the filtered pins; stage one is never looked at
    always_comb begin
        filt      = pin_filter(q.s2, q.s3, q.f);
        sprk_fall = q.f.sprocket_sense & ~filt.sprocket_sense;
        clk_ev    = ~q.f.read_clock_pulse & filt.read_clock_pulse;
        cap_ev    = ~q.f.read_capture_strobe & filt.read_capture_strobe;
        sync_ev   = ~q.f.punch_cycle_sync & filt.punch_cycle_sync;
        feed_ev   = ~q.f.feed_switch & filt.feed_switch;
    end

    // Bus decode helpers
    assign addr_ok = hsel & hready & htrans[1];
    assign wr_iot  = q.wr_pend && q.waddr == `TP_IOT_ADDR;
    assign iot     = wr_iot ? iot_decode(hwdata[11:0]) : TP_IOT_NONE;
    assign present = q.pres != '0;

    // Next-state logic for the whole block
    always_comb begin
        d.s1      = pins;
        d.s2      = q.s1;
        d.s3      = q.s2;
        d.f       = filt;
        d.wr_pend = addr_ok & hwrite;
        d.waddr   = haddr[7:0];
        d.hrdata  = q.hrdata;
        d.iallow  = q.iallow;
        // Read data prepared in the address phase, shown in the data phase
        if (addr_ok && !hwrite) begin
            if (haddr[7:0] == `TP_CTRL_ADDR) begin
                d.hrdata = {31'h0, q.iallow};
            end else if (haddr[7:0] == `TP_STAT_ADDR) begin
                d.hrdata = {22'h0, q.p_flag, q.p_sync, q.p_run, q.xc, q.arm,
                            q.rd_ena, q.rd_run, ~present, present, q.fire != '0};
            end else if (haddr[7:0] == `TP_RBUF_ADDR) begin
                d.hrdata = {24'h0, q.rbuf};
            end else begin
                d.hrdata = 32'h0; // Unmapped or write-only reads zero
            end
        end
        // Control writes
        if (q.wr_pend && q.waddr == `TP_CTRL_ADDR) begin
            d.iallow = hwdata[`TP_CTRL_IALLOW];
        end

        // Reader run request and motion enable
        d.rd_run  = q.rd_run;
        d.rd_ena  = q.rd_ena;
        d.startup = q.startup;
        if (cap_ev) begin
            d.rd_run  = 1'b0;
            d.startup = 1'b0;
        end
        if (iot == TP_IOT_READ && present) begin
            d.rd_run = 1'b1;
        end
        if (clk_ev && !q.rd_run) begin
            d.rd_ena = 1'b0;
        end else if (q.rd_run && !q.rd_ena) begin
            d.rd_ena  = 1'b1;
            d.startup = 1'b1;
        end
        // Arm follows motion enable, so hold drops while running
        d.arm = q.rd_ena;

        // Cross-coupled latch: cleared by sprocket fall, set on expiry
        d.xc = q.xc;
        if (sprk_fall) begin
            d.xc = 1'b0;
        end else if (q.pres == `TP_CNT_W'(1)) begin
            d.xc = 1'b1;
        end

        // Presence timer: a cycle counter standing in for the one-shot
        d.pres = q.pres;
        if (sprk_fall) begin
            // Slow start-up tolerates longer gaps than steady running
            d.pres = q.startup ? PRES_START_CYC : PRES_RUN_CYC;
        end else if (!q.arm && !q.xc && present) begin
            d.pres = PRES_RUN_CYC;
        end else if (present) begin
            d.pres = q.pres - `TP_CNT_W'(1);
        end

        // Run-out detector: sprocket high longer than a character period
        d.hi_cnt = q.hi_cnt;
        if (!q.f.sprocket_sense) begin
            d.hi_cnt = '0;
        end else if (q.hi_cnt != RUNOUT_CYC) begin
            d.hi_cnt = q.hi_cnt + `TP_CNT_W'(1);
        end
        d.rbuf = q.rbuf;
        if (cap_ev) begin
            // During run-out the web no longer masks the array
            d.rbuf = q.f.read_holes | {8{q.hi_cnt == RUNOUT_CYC}};
        end

        // Step pulse a short delay after each read clock
        d.step     = 1'b0;
        d.step_cnt = q.step_cnt;
        if (clk_ev) begin
            d.step_cnt = STEP_CYC;
        end else if (q.step_cnt != 8'h0) begin
            d.step_cnt = q.step_cnt - 8'h1;
            d.step     = q.step_cnt == 8'h1;
        end

        // Punch buffer: feed punches blank tape
        d.pbuf = q.pbuf;
        if (iot == TP_IOT_PUNCH) begin
            d.pbuf = hwdata[23:16];
        end else if (feed_ev) begin
            d.pbuf = 8'h0;
        end

        // Punch run and sync request
        d.p_run  = q.p_run;
        d.p_sync = q.p_sync;
        d.busy   = q.busy;
        d.fire   = q.fire;
        if (q.busy != '0) begin
            d.busy = q.busy - `TP_CNT_W'(1);
        end
        if (q.fire != '0) begin
            d.fire = q.fire - `TP_CNT_W'(1);
        end
        if (q.busy == `TP_CNT_W'(1)) begin
            d.p_run = 1'b0;
        end
        if (iot == TP_IOT_PUNCH || feed_ev) begin
            d.p_run  = 1'b1;
            d.p_sync = 1'b1;
        end else if (sync_ev && q.p_sync) begin
            d.p_sync = 1'b0;
            d.busy   = PCYCLE_CYC;
            d.fire   = FIRE_CYC;
        end

        // Punch flag: cycle end sets, write-one clears, set wins
        d.p_flag = q.p_flag;
        if (q.wr_pend && q.waddr == `TP_CTRL_ADDR && hwdata[`TP_CTRL_PCLR]) begin
            d.p_flag = 1'b0;
        end
        if (q.busy == `TP_CNT_W'(1)) begin
            d.p_flag = 1'b1;
        end
    end

    // State register; initialize empties every request and timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q        <= '0;
            q.xc     <= 1'b1;
            q.iallow <= `TP_CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // Bus answers: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.hrdata;

    // Pin outputs straight from state
    assign rdr.tape_present         = present;
    assign rdr.tape_absent          = ~present;
    assign rdr.reader_motion_enable = q.rd_ena;
    assign rdr.step_pulse           = q.step;
    assign rdr.reader_buffer        = q.rbuf;
    assign pun.punch_fire           = q.fire != '0;
    assign pun.punch_pattern_lines  = q.pbuf;
    assign pun.interrupt_request    = q.p_flag & q.iallow;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    localparam int STEP_MAX = `TP_STEP_CYC + 2;

    // Untriggered timer stays untriggered until a sprocket fall
    idle_absent_a: assert property (!present && !sprk_fall
                                    |=> rdr.tape_absent && !rdr.tape_present)
        else $error("absent not shown with idle timer");
    read_block_a: assert property (iot == TP_IOT_READ && !present && !q.rd_run
                                   |=> !q.rd_run)
        else $error("read set run without tape");
    sprk_trig_a: assert property (sprk_fall |=> rdr.tape_present && !q.xc)
        else $error("sprocket fall did not trigger");
    retrig_len_a: assert property (sprk_fall
                                   |=> q.pres == ($past(q.startup) ? PRES_START_CYC
                                                                   : PRES_RUN_CYC))
        else $error("retrigger length wrong");
    hold_keep_a: assert property (!q.arm && !q.xc && present && !sprk_fall
                                  |=> q.pres == PRES_RUN_CYC)
        else $error("hold did not keep timer");
    arm_set_a: assert property ($rose(q.rd_ena) |=> q.arm)
        else $error("arm not set with motion");
    step_gap_a: assert property (clk_ev |=> !rdr.step_pulse [*2] ##[1:STEP_MAX] rdr.step_pulse)
        else $error("step pulse missing after clock");
    motion_stop_a: assert property (clk_ev && !q.rd_run |=> !q.rd_ena)
        else $error("motion not stopped");
    sync_fire_a: assert property (sync_ev && q.p_sync && iot != TP_IOT_PUNCH
                                  && !feed_ev
                                  |=> pun.punch_fire && q.fire == FIRE_CYC && !q.p_sync)
        else $error("sync did not start fire");
    cycle_end_a: assert property (q.busy == `TP_CNT_W'(1) && iot != TP_IOT_PUNCH
                                  && !feed_ev
                                  |=> !q.p_run && q.p_flag)
        else $error("cycle end did not flag");
    // Flag set at cycle end with interrupts allowed must raise the request
    irq_raise_a: assert property (q.busy == `TP_CNT_W'(1) && q.iallow
                                  && !(q.wr_pend && q.waddr == `TP_CTRL_ADDR)
                                  |=> pun.interrupt_request)
        else $error("interrupt not raised");
    pbuf_load_a: assert property (iot == TP_IOT_PUNCH
                                  |=> pun.punch_pattern_lines == $past(hwdata[23:16]))
        else $error("punch buffer not loaded");

    read_start_c: cover property (iot == TP_IOT_READ ##[1:4] q.rd_ena);
    punch_done_c: cover property ($rose(q.p_flag));
    runout_c:     cover property ($fell(present));
endmodule : tp_ctrl

// ==== rtl/tp_regs.svh ====
// Constants for the paper-tape presence and punch controller.
// Assumes a 40 MHz hclk; included by the package and the top module.
`ifndef TP_REGS_SVH
`define TP_REGS_SVH
`define TP_IOT_ADDR     8'h00
`define TP_CTRL_ADDR    8'h04
`define TP_STAT_ADDR    8'h08
`define TP_RBUF_ADDR    8'h0c
`define TP_CTRL_IALLOW  0
`define TP_CTRL_PCLR    1
`define TP_CTRL_RST     1'b1
`define TP_IOT_RD0      12'o6014
`define TP_IOT_RD1      12'o6016
`define TP_IOT_PN0      12'o6024
`define TP_IOT_PN1      12'o6026
`define TP_CNT_W        20
`define TP_CLK_MHZ      40
`define TP_STEP_NS      2000
`define TP_STEP_CYC     ((`TP_STEP_NS * `TP_CLK_MHZ) / 1000)
`define TP_PRES_START_US 10000
`define TP_PRES_RUN_US  8500
`define TP_RUNOUT_US    3340
`define TP_FIRE_US      10000
`define TP_PCYCLE_US    20000
`define TP_PRES_START_CYC (`TP_PRES_START_US * `TP_CLK_MHZ)
`define TP_PRES_RUN_CYC (`TP_PRES_RUN_US * `TP_CLK_MHZ)
`define TP_RUNOUT_CYC   (`TP_RUNOUT_US * `TP_CLK_MHZ)
`define TP_FIRE_CYC     (`TP_FIRE_US * `TP_CLK_MHZ)
`define TP_PCYCLE_CYC   (`TP_PCYCLE_US * `TP_CLK_MHZ)
`endif

// ==== rtl/tp_pkg.sv ====
// Types for the paper-tape presence and punch controller.
// Assumes tp_regs.svh is on the include path.
`include "tp_regs.svh"
package tp_pkg;
    // Pins from the mechanism, all asynchronous
    typedef struct packed {
        logic       sprocket_sense;
        logic       read_clock_pulse;
        logic       read_capture_strobe;
        logic       punch_cycle_sync;
        logic       feed_switch;
        logic [7:0] read_holes;
    } tp_pins_t;
    // Reader-side outputs
    typedef struct packed {
        logic       tape_present;
        logic       tape_absent;
        logic       reader_motion_enable;
        logic       step_pulse;
        logic [7:0] reader_buffer;
    } tp_rdr_out_t;
    // Punch-side outputs
    typedef struct packed {
        logic       punch_fire;
        logic [1:8] punch_pattern_lines;
        logic       interrupt_request;
    } tp_pun_out_t;
    typedef enum logic [1:0] {TP_IOT_NONE, TP_IOT_READ, TP_IOT_PUNCH} tp_iot_t;
    // Whole state of the controller
    typedef struct packed {
        tp_pins_t              s1, s2, s3, f;
        logic [31:0]           hrdata;
        logic                  wr_pend;
        logic [7:0]            waddr;
        logic                  iallow;
        logic                  rd_run, rd_ena, arm, xc, startup;
        logic [`TP_CNT_W-1:0]  pres, hi_cnt;
        logic [7:0]            step_cnt;
        logic                  step;
        logic [7:0]            rbuf;
        logic [4:11]           pbuf;
        logic                  p_run, p_sync, p_flag;
        logic [`TP_CNT_W-1:0]  busy, fire;
    } tp_state_t;
endpackage : tp_pkg

// ==== bench/tp_mech_model.sv ====
// Behavioural reader and punch mechanism facing the tape controller.
// Assumes hclk from the bench; every pin changes just after a rising edge.
module tp_mech_model (
    // Clock and bench controls
    input  wire logic                hclk,
    input  wire logic                loaded,
    input  wire logic                feed,
    input  wire logic [7:0]          holes,
    // Controller outputs
    input  wire tp_pkg::tp_rdr_out_t rdr,
    // Pins into the controller
    output tp_pkg::tp_pins_t         pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import tp_pkg::*;

    int   hole_n = 0;  // Cycles left showing a feed hole
    logic clk_p  = 1'b0;  // Read clock pulse
    logic strb   = 1'b0;  // Capture strobe
    logic sync   = 1'b0;  // Punch cycle sync

    // Each step shows a hole for ten cycles, then the web drops the line
    always @(posedge hclk) begin
        if (rdr.step_pulse === 1'b1) begin
            hole_n <= 10;
        end else if (hole_n > 0) begin
            hole_n <= hole_n - 1;
        end
    end

    // Clock runs only with motion; strobe is skipped once motion stops
    initial begin
        forever begin
            @(posedge hclk);
            if (rdr.reader_motion_enable === 1'b1) begin
                repeat (20) @(posedge hclk);
                clk_p <= 1'b1;
                repeat (4) @(posedge hclk);
                clk_p <= 1'b0;
                repeat (110) @(posedge hclk);
                if (rdr.reader_motion_enable === 1'b1) begin
                    strb <= 1'b1;
                end
                repeat (4) @(posedge hclk);
                strb <= 1'b0;
                repeat (12) @(posedge hclk);
            end
        end
    end

    // Motor runs free: one sync per revolution, period outlasts busy
    initial begin
        forever begin
            repeat (116) @(posedge hclk);
            sync <= 1'b1;
            repeat (4) @(posedge hclk);
            sync <= 1'b0;
        end
    end

    // No tape reads as a permanent hole
    assign pins = '{sprocket_sense: !loaded || (hole_n > 0), read_clock_pulse: clk_p,
                    read_capture_strobe: strb, punch_cycle_sync: sync,
                    feed_switch: feed, read_holes: holes};
endmodule : tp_mech_model

// ==== bench/tp_ctrl_tb.sv ====
// Self-checking bench for the tape controller over AHB-Lite.
// Assumes tp_regs.svh on the include path; timers shortened by parameters.
`include "tp_regs.svh"
module tp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tp_pkg::*;

    localparam int FIRE = 40;  // Fire length set below
    // Bus and bench stimulus
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic        hwrite = 1'b0, loaded = 1'b0, feed = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_data;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp;
    logic [7:0]  holes = 8'h00;
    tp_pins_t    pins;
    tp_rdr_out_t rdr;
    tp_pun_out_t pun;
    int          miscompares = 0, check_count = 0, seed = 80;
    logic [31:0] exp_q[$], msk_q[$];
    logic [1:8]  pat_q[$];
    event        rd_ev;

    tp_ctrl #(.PRES_START_CYC(20'd400), .PRES_RUN_CYC(20'd340), .RUNOUT_CYC(20'd130),
              .FIRE_CYC(20'd40), .PCYCLE_CYC(20'd80)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
        .rdr(rdr), .pun(pun));
    tp_mech_model mech (.hclk(hclk), .loaded(loaded), .feed(feed), .holes(holes),
                        .rdr(rdr), .pins(pins));

    // 40 MHz clock
    initial begin
        forever #12.5 hclk = ~hclk;
    end

    task automatic check_word(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic results;
        if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    // Single word transfer; holds each phase until hready is seen high
    // No wait limit here: only the watchdog ends a stuck transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd_data = hrdata;
        if (!wr) -> rd_ev;
    endtask : bus

    // Read with a note of the expected masked value
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic wait_strb(output bit seen);
        seen = 0;
        for (int n = 0; n < 400 && !seen; n++) begin
            @(posedge hclk);
            seen = (pins.read_capture_strobe === 1'b1);
        end
    endtask : wait_strb

    // Keep reading: one command between each strobe and the next clock
    task automatic run_chars(input int cnt);
        bit seen;
        for (int i = 0; i < cnt; i++) begin
            wait_strb(seen);
            repeat (8) @(posedge hclk);
            bus(1'b1, `TP_IOT_ADDR, {20'h0, i[0] ? `TP_IOT_RD0 : `TP_IOT_RD1});
            rd(`TP_RBUF_ADDR, {24'h0, holes}, 32'hff);
            holes <= 8'($random(seed));
        end
    endtask : run_chars

    // Wait out fire, then the rest of the busy span
    task automatic wait_fire;
        for (int n = 0; n < 600 && pun.punch_fire !== 1'b1; n++) @(posedge hclk);
        for (int n = 0; n < 600 && pun.punch_fire === 1'b1; n++) @(posedge hclk);
        repeat (48) @(posedge hclk);
    endtask : wait_fire

    // Read results taken oldest first
    always @(rd_ev) begin
        check_word("hrdata", exp_q.pop_front(), rd_data & msk_q.pop_front());
    end

    // Step follows each clock pulse by the fixed delay plus input filtering
    always @(posedge pins.read_clock_pulse) begin : step_mon
        int n;
        n = 0;
        while (rdr.step_pulse !== 1'b1 && n < 200) begin
            @(posedge hclk);
            #1;
            n++;
        end
        check_word("step delay", 32'h1, {31'h0, n >= 80 && n <= 88});
    end

    // Pattern and width of every fire pulse
    always @(posedge pun.punch_fire) begin : fire_mon
        int n;
        logic [7:0] e;
        e = pat_q.pop_front();
        check_word("punch lines", {24'h0, e}, {24'h0, pun.punch_pattern_lines});
        n = 0;
        while (pun.punch_fire === 1'b1 && n < 200) begin
            @(posedge hclk);
            #1;
            n++;
        end
        check_word("fire width", FIRE, n);
    end

    // Watchdog, well past the expected run length
    initial begin
        repeat (40000) @(posedge hclk);
        miscompares++;
        results();
    end

    // Main sequence: reset, reader, run-out, punch
    initial begin : main
        bit         seen;
        logic [7:0] p;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        holes   <= 8'($random(seed));
        rd(`TP_STAT_ADDR, 32'h004, 32'h3bf);
        rd(`TP_CTRL_ADDR, 32'h1, 32'h3);
        rd(`TP_RBUF_ADDR, 32'h0, 32'hff);
        rd(8'h10, 32'h0, 32'hffffffff);
        bus(1'b1, `TP_IOT_ADDR, {20'h0, `TP_IOT_RD0});
        rd(`TP_STAT_ADDR, 32'h004, 32'h03f);
        loaded <= 1'b1;
        repeat (600) @(posedge hclk);  // Longer than any reload: only the hold keeps it
        rd(`TP_STAT_ADDR, 32'h002, 32'h07f);
        bus(1'b1, `TP_IOT_ADDR, {20'h0, `TP_IOT_RD1});
        repeat (6) @(posedge hclk);
        rd(`TP_STAT_ADDR, 32'h03a, 32'h03f);
        run_chars(6);
        rd(`TP_STAT_ADDR, 32'h03a, 32'h03f);
        repeat (700) @(posedge hclk);
        rd(`TP_STAT_ADDR, 32'h002, 32'h03e);
        bus(1'b1, `TP_IOT_ADDR, {20'h0, `TP_IOT_RD0});
        run_chars(2);
        // Tape leaves just after a strobe, so strobes follow the run-out span
        wait_strb(seen);
        loaded <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            repeat (8) @(posedge hclk);
            bus(1'b1, `TP_IOT_ADDR, {20'h0, `TP_IOT_RD0});
            wait_strb(seen);
        end
        rd(`TP_RBUF_ADDR, 32'hff, 32'hff);
        repeat (400) @(posedge hclk);
        rd(`TP_STAT_ADDR, 32'h004, 32'h01e);
        // Two punch codes with and without interrupts, then the feed switch
        for (int k = 0; k < 3; k++) begin
            p = (k == 2) ? 8'h00 : 8'($random(seed));
            pat_q.push_back(p);
            bus(1'b1, `TP_CTRL_ADDR, {31'h0, k == 0});
            if (k == 2) begin
                feed <= 1'b1;
                repeat (8) @(posedge hclk);
                feed <= 1'b0;
            end else begin
                bus(1'b1, `TP_IOT_ADDR, {8'h0, p, 4'h0, k[0] ? `TP_IOT_PN1 : `TP_IOT_PN0});
            end
            wait_fire();
            rd(`TP_STAT_ADDR, 32'h200, 32'h381);
            check_word("interrupt", {31'h0, k == 0}, {31'h0, pun.interrupt_request});
            check_word("held lines", {24'h0, p}, {24'h0, pun.punch_pattern_lines});
            bus(1'b1, `TP_CTRL_ADDR, 32'h3);
            rd(`TP_STAT_ADDR, 32'h000, 32'h200);
            check_word("interrupt", 32'h0, {31'h0, pun.interrupt_request});
        end
        check_word("fire count", 32'h0, pat_q.size());
        results();
    end
endmodule : tp_ctrl_tb
